// *** hdl/pcg_pkg.sv ***
// Constants, register map and unit layout of the peripheral clock gating block
// ----------------------------------------------------------------------------
// Function
// - Each gating bit drives exactly one unit's clock enable; one runs, zero stops.
// - Access to a unit whose clock is gated off ends in a bus fault.
// - All gating bits reset to zero unless stated otherwise, so units start unclocked.
// - Three gating registers exist: run, sleep and deep sleep.
// - With automatic gating selected, sleep modes apply their own gating registers.
// - Run register bit 17 enables general timer one, read-write, resets zero.
// - Run register bit 16 enables general timer zero, read-write, resets zero.
// - Run register bit 12 enables the I2C unit, read-write, resets zero.
// - Run register bit 8 enables the quadrature encoder unit, read-write, resets zero.
// - Run register bit 0 enables the serial port unit, read-write, resets zero.
// - Reserved run register bits are read-only zero; software preserves them.
// - Run register decodes at offset 0x104 from the system control base.
// - Sleep register at 0x114 gates two comparators and four timers; rest read-only.
// - The hibernation unit's gating bit resets to one, so it runs out of reset.
// ----------------------------------------------------------------------------
package pcg_pkg;

    // ------------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------------
    localparam int PCG_AW = 12;
    localparam int PCG_DW = 32;
    localparam logic [31:0] PCG_SYSCTL_BASE = 32'h400f_e000;
    localparam logic [PCG_AW-1:0] PCG_OFF_RUN = 12'h104;
    localparam logic [PCG_AW-1:0] PCG_OFF_SLEEP = 12'h114;
    localparam logic [PCG_AW-1:0] PCG_OFF_DEEP = 12'h124;
    localparam logic [PCG_AW-1:0] PCG_OFF_CFG = 12'h130;
    localparam logic [PCG_AW-1:0] PCG_OFF_STAT = 12'h140;
    localparam logic [PCG_AW-1:0] PCG_OFF_MASK = 12'h144;
    localparam logic [PCG_AW-1:0] PCG_OFF_FUNIT = 12'h148;
    localparam logic [PCG_AW-1:0] PCG_OFF_APPLIED = 12'h14c;

    // ------------------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------------------
    localparam logic [PCG_DW-1:0] PCG_RUN_WMASK = 32'h0003_1101;
    localparam logic [PCG_DW-1:0] PCG_SLP_WMASK = 32'h0300_000f;
    localparam logic [PCG_DW-1:0] PCG_GATE_RST = 32'h0000_0000;
    localparam int PCG_CFG_AUTO_BIT = 0;
    localparam int PCG_CFG_HIB_BIT = 6;
    localparam logic [PCG_DW-1:0] PCG_CFG_WMASK = 32'h0000_0041;
    localparam logic [PCG_DW-1:0] PCG_CFG_RST = 32'h0000_0040;
    localparam int PCG_STAT_FAULT_BIT = 0;
    localparam int PCG_NEVENTS = 1;

    // ------------------------------------------------------------------------
    // Units: 0 serial, 1 quad encoder, 2 i2c, 3..6 timers 0..3, 7..8 comparators,
    // 9 hibernation
    // ------------------------------------------------------------------------
    localparam int PCG_UNITS = 10;
    localparam int PCG_UW = 4;
    localparam int PCG_HIB_UNIT = 9;
    localparam int PCG_RUN_POS [PCG_UNITS] = '{0, 8, 12, 16, 17, 0, 0, 0, 0, 0};
    localparam bit PCG_RUN_HAS [PCG_UNITS] = '{1, 1, 1, 1, 1, 0, 0, 0, 0, 0};
    localparam int PCG_SLP_POS [PCG_UNITS] = '{0, 0, 0, 0, 1, 2, 3, 24, 25, 0};
    localparam bit PCG_SLP_HAS [PCG_UNITS] = '{0, 0, 0, 1, 1, 1, 1, 1, 1, 0};

    typedef enum logic [1:0] {
        PCG_MODE_RUN,
        PCG_MODE_SLEEP,
        PCG_MODE_DEEP
    } pcg_mode_t;

endpackage

// *** hdl/pcg_gate.sv ***
// Peripheral clock gating control with register slave, fault check and interrupt
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module pcg_gate
    import pcg_pkg::*;
#(
    parameter int UNITS = PCG_UNITS
) (
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [PCG_AW-1:0] regAddr,
    input wire logic [PCG_DW-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [PCG_DW-1:0] regRdData,
    // Power mode from the power controller, same clock
    input wire logic sleepMode,
    input wire logic deepSleepMode,
    // Peripheral access check
    input wire logic perReq,
    input wire logic [PCG_UW-1:0] perUnit,
    output logic perDone,
    output logic perFault,
    // Unit clock enables, fed to the clock gate cells
    output logic [UNITS-1:0] unitClkEn,
    output logic irq
);

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [PCG_DW-1:0] runGateReg_q;
    logic [PCG_DW-1:0] sleepGateReg_q;
    logic [PCG_DW-1:0] deepSleepGateReg_q;
    logic [PCG_DW-1:0] runClockConfig_q;
    logic [PCG_NEVENTS-1:0] intStat_q;
    logic [PCG_NEVENTS-1:0] intMask_q;
    logic [PCG_UW-1:0] faultUnit_q;
    logic [PCG_DW-1:0] rdData_q;
    logic [UNITS-1:0] unitClkEn_q;
    logic [UNITS-1:0] unitClkEn_d;
    logic perDone_q;
    logic perFault_q;
    logic faultEvent;
    pcg_mode_t mode;

    logic autoGateSelect;
    logic wrRun;
    logic wrSleep;
    logic wrDeep;
    logic wrCfg;
    logic wrStat;
    logic wrMask;

    assign autoGateSelect = runClockConfig_q[PCG_CFG_AUTO_BIT];
    assign wrRun = regWr && (regAddr == PCG_OFF_RUN);
    assign wrSleep = regWr && (regAddr == PCG_OFF_SLEEP);
    assign wrDeep = regWr && (regAddr == PCG_OFF_DEEP);
    assign wrCfg = regWr && (regAddr == PCG_OFF_CFG);
    assign wrStat = regWr && (regAddr == PCG_OFF_STAT);
    assign wrMask = regWr && (regAddr == PCG_OFF_MASK);

    // ------------------------------------------------------------------------
    // Gating registers
    // ------------------------------------------------------------------------
    // Reserved bits never store, so they read zero whatever software writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            runGateReg_q <= PCG_GATE_RST;
        end else if (wrRun) begin
            runGateReg_q <= regWrData & PCG_RUN_WMASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleepGateReg_q <= PCG_GATE_RST;
        end else if (wrSleep) begin
            sleepGateReg_q <= regWrData & PCG_SLP_WMASK;
        end
    end

    // Deep-sleep register shares the sleep layout
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            deepSleepGateReg_q <= PCG_GATE_RST;
        end else if (wrDeep) begin
            deepSleepGateReg_q <= regWrData & PCG_SLP_WMASK;
        end
    end

    // Hibernation gate lives here and comes up set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            runClockConfig_q <= PCG_CFG_RST;
        end else if (wrCfg) begin
            runClockConfig_q <= regWrData & PCG_CFG_WMASK;
        end
    end

    // ------------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------------
    // Deep sleep outranks sleep if the power controller raises both
    always_comb begin
        if (!autoGateSelect) begin
            mode = PCG_MODE_RUN;
        end else if (deepSleepMode) begin
            mode = PCG_MODE_DEEP;
        end else if (sleepMode) begin
            mode = PCG_MODE_SLEEP;
        end else begin
            mode = PCG_MODE_RUN;
        end
    end

    // ------------------------------------------------------------------------
    // Per-unit enable selection
    // ------------------------------------------------------------------------
    for (genvar u = 0; u < UNITS; u++) begin : g_unit
        logic runBit;
        logic slpBit;
        logic deepBit;
        if (u == PCG_HIB_UNIT) begin : g_hib
            assign runBit = runClockConfig_q[PCG_CFG_HIB_BIT];
            assign slpBit = runClockConfig_q[PCG_CFG_HIB_BIT];
            assign deepBit = runClockConfig_q[PCG_CFG_HIB_BIT];
        end else begin : g_std
            // Units absent from a register stay unclocked in that mode
            assign runBit = PCG_RUN_HAS[u] && runGateReg_q[PCG_RUN_POS[u]];
            assign slpBit = PCG_SLP_HAS[u] && sleepGateReg_q[PCG_SLP_POS[u]];
            assign deepBit = PCG_SLP_HAS[u] && deepSleepGateReg_q[PCG_SLP_POS[u]];
        end
        always_comb begin
            case (mode)
                PCG_MODE_RUN: unitClkEn_d[u] = runBit;
                PCG_MODE_SLEEP: unitClkEn_d[u] = slpBit;
                PCG_MODE_DEEP: unitClkEn_d[u] = deepBit;
                default: unitClkEn_d[u] = runBit;
            endcase
        end
    end

    // Registered so the gate cells see a clean, clock-aligned level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unitClkEn_q <= '0;
        end else begin
            unitClkEn_q <= unitClkEn_d;
        end
    end

    assign unitClkEn = unitClkEn_q;

    // ------------------------------------------------------------------------
    // Access check
    // ------------------------------------------------------------------------
    logic unitKnown;
    logic unitOn;
    assign unitKnown = (32'(perUnit) < UNITS);
    assign unitOn = unitKnown && unitClkEn_q[perUnit];
    // Software must enable a unit before use; anything else faults
    assign faultEvent = perReq && !unitOn;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            perDone_q <= 1'b0;
            perFault_q <= 1'b0;
        end else begin
            perDone_q <= perReq && unitOn;
            perFault_q <= faultEvent;
        end
    end

    assign perDone = perDone_q;
    assign perFault = perFault_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            faultUnit_q <= '0;
        end else if (faultEvent) begin
            faultUnit_q <= perUnit;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------------
    // A fault in the same cycle as its clear keeps the bit set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intStat_q <= '0;
        end else begin
            intStat_q[PCG_STAT_FAULT_BIT] <= faultEvent ||
                (intStat_q[PCG_STAT_FAULT_BIT] &&
                 !(wrStat && regWrData[PCG_STAT_FAULT_BIT]));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intMask_q <= '0;
        end else if (wrMask) begin
            intMask_q <= regWrData[PCG_NEVENTS-1:0];
        end
    end

    assign irq = |(intStat_q & intMask_q);

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    logic [PCG_DW-1:0] rdMux;
    always_comb begin
        rdMux = '0;
        case (regAddr)
            PCG_OFF_RUN: rdMux = runGateReg_q;
            PCG_OFF_SLEEP: rdMux = sleepGateReg_q;
            PCG_OFF_DEEP: rdMux = deepSleepGateReg_q;
            PCG_OFF_CFG: rdMux = runClockConfig_q;
            PCG_OFF_STAT: rdMux[PCG_NEVENTS-1:0] = intStat_q;
            PCG_OFF_MASK: rdMux[PCG_NEVENTS-1:0] = intMask_q;
            PCG_OFF_FUNIT: rdMux[PCG_UW-1:0] = faultUnit_q;
            PCG_OFF_APPLIED: rdMux[UNITS-1:0] = unitClkEn_q;
            default: rdMux = '0;
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_q <= '0;
        end else if (regRd) begin
            rdData_q <= rdMux;
        end else begin
            rdData_q <= '0;
        end
    end

    assign regRdData = rdData_q;

endmodule

// *** bench/pcg_gate_props.sv ***
// Concurrent checks on the ports of the clock gating block
`timescale 1ns/1ps
module pcg_gate_props
    import pcg_pkg::*;
#(
    parameter int UNITS = PCG_UNITS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [PCG_AW-1:0] regAddr,
    input wire logic regRd,
    input wire logic regWr,
    input wire logic [PCG_DW-1:0] regRdData,
    input wire logic sleepMode,
    input wire logic deepSleepMode,
    input wire logic perReq,
    input wire logic [PCG_UW-1:0] perUnit,
    input wire logic perDone,
    input wire logic perFault,
    input wire logic [UNITS-1:0] unitClkEn
);
    logic [1:0] age_q;
    logic [1:0] modeNow;
    logic onNow;
    // Age keeps the history checks away from values held during reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    assign modeNow = {sleepMode, deepSleepMode};
    assign onNow = (perUnit < 4'(UNITS)) && unitClkEn[perUnit];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_gated_fault: assert property (perReq && !onNow |=> perFault && !perDone)
        else $error("gated access did not fault");
    a_open_done: assert property (perReq && onNow |=> perDone && !perFault)
        else $error("enabled access did not complete");
    a_idle_quiet: assert property (!perReq |=> !perDone && !perFault)
        else $error("access answer without request");
    a_rd_once: assert property (!regRd |=> regRdData == 32'h0)
        else $error("read data outside its cycle");
    a_rsvd_zero: assert property (regRd && regAddr == PCG_OFF_RUN |=>
        (regRdData & ~PCG_RUN_WMASK) == 32'h0)
        else $error("reserved run bits read nonzero");
    a_reset_off: assert property (age_q == 2'h1 |->
        unitClkEn[8:0] == 9'h0 && unitClkEn[9])
        else $error("enables wrong after reset");
    a_en_steady: assert property (age_q == 2'h3 && !$past(regWr) && !$past(regWr, 2)
        && $past(modeNow) == $past(modeNow, 2) |-> $stable(unitClkEn))
        else $error("enables moved without cause");
    a_run_missing: assert property (age_q == 2'h3 && $past(modeNow) == 2'h0
        && $past(modeNow, 2) == 2'h0 |-> unitClkEn[8:5] == 4'h0)
        else $error("sleep-only unit clocked in run");
    c_fault: cover property (perReq && !onNow);
    c_done: cover property (perReq && onNow);
    c_sleep: cover property (sleepMode && unitClkEn[5]);
endmodule

// *** bench/pcg_unit_model.sv ***
// Peripheral units that advance only on an enabled clock
`timescale 1ns/1ps
module pcg_unit_model
    import pcg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [PCG_UNITS-1:0] unitClkEn,
    output logic [15:0] ticks [PCG_UNITS]
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PCG_UNITS; i++) begin
                ticks[i] <= 16'h0;
            end
        end else begin
            for (int i = 0; i < PCG_UNITS; i++) begin
                if (unitClkEn[i]) begin
                    ticks[i] <= ticks[i] + 16'h1;
                end
            end
        end
    end
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the clock gating block
`timescale 1ns/1ps
module testbench;
    import pcg_pkg::*;
    logic clk, rst, regWr, regRd, perReq, perDone, perFault, irq, sleepMode, deepSleepMode;
    logic [PCG_AW-1:0] regAddr;
    logic [PCG_DW-1:0] regWrData, regRdData;
    logic [PCG_UW-1:0] perUnit;
    logic [PCG_UNITS-1:0] unitClkEn;
    logic [15:0] ticks [PCG_UNITS];
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    pcg_gate DUT (.clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .sleepMode,
        .deepSleepMode, .perReq, .perUnit, .perDone, .perFault, .unitClkEn, .irq);
    pcg_unit_model UNITS_M (.clk, .rst, .unitClkEn, .ticks);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // The whole sequence needs under a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(regRdData, e, "read");
    endtask
    task automatic acc(input int u, input logic f);
        @(posedge clk);
        perUnit <= 4'(u);
        perReq <= 1'b1;
        @(posedge clk);
        perReq <= 1'b0;
        #1 chk(32'({perFault, perDone}), 32'({f, ~f}), "access");
    endtask
    // Enables are registered, so allow the one cycle of lag
    task automatic en(input logic [9:0] e);
        repeat (2) @(posedge clk);
        #1 chk(32'(unitClkEn), 32'(e), "enables");
    endtask
    initial begin
        {rst, regWr, regRd, perReq, sleepMode, deepSleepMode} = 6'h20;
        regAddr = '0;
        regWrData = '0;
        perUnit = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        en(10'h200);
        rd(PCG_OFF_RUN, 32'h0);
        rd(PCG_OFF_SLEEP, 32'h0);
        rd(PCG_OFF_CFG, 32'h40);
        acc(0, 1'b1);
        $display("test reset done");
        wr(PCG_OFF_RUN, 32'hffff_ffff);
        rd(PCG_OFF_RUN, 32'h0003_1101);
        en(10'h21f);
        rd(PCG_OFF_APPLIED, 32'h0000_021f);
        wr(12'h100, 32'hffff_ffff);
        rd(12'h100, 32'h0);
        for (int u = 0; u < 11; u++) begin
            acc(u, !(u < 5 || u == 9));
        end
        chk(32'(ticks[7]), 32'h0, "comparator idle");
        chk(32'(ticks[0] != 16'h0), 32'h1, "serial runs");
        rd(PCG_OFF_FUNIT, 32'ha);
        rd(PCG_OFF_STAT, 32'h1);
        chk(32'(irq), 32'h0, "irq masked");
        wr(PCG_OFF_MASK, 32'h1);
        #1 chk(32'(irq), 32'h1, "irq raised");
        rd(PCG_OFF_MASK, 32'h1);
        wr(PCG_OFF_STAT, 32'h1);
        #1 chk(32'(irq), 32'h0, "irq cleared");
        // A fault and its clear in one cycle leave the status set
        fork
            acc(5, 1'b1);
            wr(PCG_OFF_STAT, 32'h1);
        join
        rd(PCG_OFF_STAT, 32'h1);
        chk(32'(irq), 32'h1, "set beats clear");
        wr(PCG_OFF_STAT, 32'h1);
        $display("test fault done");
        wr(PCG_OFF_SLEEP, 32'hffff_ffff);
        rd(PCG_OFF_SLEEP, 32'h0300_000f);
        wr(PCG_OFF_DEEP, 32'h0100_0001);
        rd(PCG_OFF_DEEP, 32'h0100_0001);
        @(posedge clk);
        sleepMode <= 1'b1;
        en(10'h21f);
        wr(PCG_OFF_CFG, 32'h41);
        en(10'h3f8);
        @(posedge clk);
        deepSleepMode <= 1'b1;
        en(10'h288);
        @(posedge clk);
        {sleepMode, deepSleepMode} <= 2'h0;
        wr(PCG_OFF_CFG, 32'h0);
        en(10'h01f);
        acc(9, 1'b1);
        $display("test modes done");
        report_and_stop();
    end
endmodule
bind pcg_gate pcg_gate_props #(.UNITS(UNITS)) CHK (.clk, .rst, .regAddr, .regRd, .regWr,
    .regRdData, .sleepMode, .deepSleepMode, .perReq, .perUnit, .perDone, .perFault,
    .unitClkEn);
